//--- rtl/asl_target.sv
`timescale 1ns/1ps
module asl_target #(
  parameter int unsigned REG_DEPTH = 16
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // bus side
  asl_bus_if.target bus,
  // address straps, multi-level code
  input wire logic [1:0] addr_strap_low_in,
  input wire logic addr_strap_high_in,
  // slot selection
  output logic [6:0] bus_target_address_out,
  output logic [3:0] slot_out,
  output logic slot_source_override_out,
  output logic left_channel_out,
  // register write notification
  output logic reg_wr_out,
  output logic [7:0] reg_wr_addr_out,
  output logic [7:0] reg_wr_data_out,
  // status
  output logic busy_out
);
  localparam int unsigned AW = $clog2(REG_DEPTH);
  localparam int unsigned OVR_BIT_I = asl_pkg::OVR_BIT;
  localparam int unsigned SLOT_LSB_I = asl_pkg::SLOT_LSB;
  localparam int unsigned FMT_LSB_I = asl_pkg::FMT_LSB;
  localparam logic [7:0] REG_FMT = asl_pkg::REG_FMT;
  localparam logic [7:0] REG_SLOT = asl_pkg::REG_SLOT;
  typedef enum {T_IDLE, T_RX, T_RX_ACK, T_TX, T_TX_ACK, T_IGNORE} asl_tstate_t;
  typedef enum {P_ADDR, P_REG, P_DATA} asl_phase_t;

  asl_tstate_t st_reg, st_next;
  asl_phase_t ph_reg, ph_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] sh_reg, sh_next;
  logic [7:0] tx_reg, tx_next;
  logic [7:0] ptr_reg, ptr_next;
  logic oe_reg, oe_next;
  logic rd_reg, rd_next;
  logic ack_reg, ack_next;
  logic wr_reg, wr_next;
  logic [7:0] wa_reg, wa_next;
  logic [7:0] wd_reg, wd_next;
  logic [7:0] mem_reg [REG_DEPTH];
  logic [7:0] mem_next [REG_DEPTH];
  logic [6:0] addr_reg, addr_next, addr_off;
  logic [3:0] slot_reg, slot_next;
  logic ovr_reg, ovr_next;
  logic left_reg, left_next;
  logic sda, start, stop, rise, fall;

  // addresses past the array read as zero and drop writes
  function automatic logic in_map(input logic [7:0] a);
    in_map = (32'(a) < REG_DEPTH);
  endfunction : in_map

  function automatic logic [7:0] rd_byte(input logic [7:0] a, input logic [7:0] m [REG_DEPTH]);
    rd_byte = in_map(a) ? m[a[AW-1:0]] : 8'h00;
  endfunction : rd_byte

  asl_line_mon u_mon (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .scl_in(bus.scl),
    .sda_in(bus.sda),
    .sda_out(sda),
    .start_out(start),
    .stop_out(stop),
    .rise_out(rise),
    .fall_out(fall)
  );

  // open drain: only ever pulls low, never holds scl
  assign bus.tgt_sda_o = 1'b0;
  assign bus.tgt_sda_oe = oe_reg;

  // protocol engine and register file
  always_comb begin
    st_next = st_reg;
    ph_next = ph_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    tx_next = tx_reg;
    ptr_next = ptr_reg;
    oe_next = oe_reg;
    rd_next = rd_reg;
    ack_next = ack_reg;
    wr_next = 1'b0;
    wa_next = wa_reg;
    wd_next = wd_reg;
    mem_next = mem_reg;
    if (stop) begin
      st_next = T_IDLE;
      oe_next = 1'b0;
    end else if (start) begin
      // also a repeated start, pointer kept
      st_next = T_RX;
      ph_next = P_ADDR;
      cnt_next = 4'h0;
      oe_next = 1'b0;
    end else begin
      case (st_reg)
        T_RX: begin
          if (rise) begin
            sh_next = {sh_reg[6:0], sda};
            cnt_next = cnt_reg + 4'h1;
          end else if (fall && cnt_reg == 4'h8) begin
            cnt_next = 4'h0;
            st_next = T_RX_ACK;
            oe_next = 1'b1;
            case (ph_reg)
              P_ADDR: begin
                if (sh_reg[7:1] != addr_reg) begin
                  st_next = T_IGNORE;
                  oe_next = 1'b0;
                end else begin
                  rd_next = sh_reg[0];
                end
              end
              P_REG: ptr_next = sh_reg;
              default: begin
                if (in_map(ptr_reg)) begin
                  mem_next[ptr_reg[AW-1:0]] = sh_reg;
                end
                wr_next = 1'b1;
                wa_next = ptr_reg;
                wd_next = sh_reg;
                ptr_next = ptr_reg + 8'h01;
              end
            endcase
          end
        end
        T_RX_ACK: begin
          // ack held low for the whole high phase, released on the fall
          if (fall) begin
            oe_next = 1'b0;
            if (ph_reg == P_ADDR && rd_reg) begin
              tx_next = rd_byte(ptr_reg, mem_reg);
              ptr_next = ptr_reg + 8'h01;
              oe_next = ~tx_next[7];
              st_next = T_TX;
            end else begin
              st_next = T_RX;
              ph_next = (ph_reg == P_ADDR) ? P_REG : P_DATA;
            end
          end
        end
        T_TX: begin
          if (fall) begin
            cnt_next = cnt_reg + 4'h1;
            if (cnt_reg == 4'h7) begin
              cnt_next = 4'h0;
              oe_next = 1'b0;
              st_next = T_TX_ACK;
            end else begin
              tx_next = {tx_reg[6:0], 1'b0};
              oe_next = ~tx_reg[6];
            end
          end
        end
        T_TX_ACK: begin
          if (rise) begin
            ack_next = ~sda;
          end
          if (fall) begin
            if (ack_reg) begin
              tx_next = rd_byte(ptr_reg, mem_reg);
              ptr_next = ptr_reg + 8'h01;
              oe_next = ~tx_next[7];
              st_next = T_TX;
            end else begin
              st_next = T_IGNORE;
            end
          end
        end
        default: ;
      endcase
    end
  end

  // slot choice and channel mapping
  always_comb begin
    ovr_next = mem_reg[REG_FMT[AW-1:0]][OVR_BIT_I];
    addr_off = addr_reg - asl_pkg::BASE_ADDR;
    slot_next = ovr_next ? mem_reg[REG_SLOT[AW-1:0]][SLOT_LSB_I +: 4]
      : addr_off[3:0];
    if (mem_reg[REG_FMT[AW-1:0]][FMT_LSB_I +: 3] == asl_pkg::FMT_I2S) begin
      left_next = slot_next[0];
    end else begin
      left_next = ~slot_next[0];
    end
  end

  // straps are caught while reset is held, so they never change mid-transfer
  always_comb begin
    addr_next = addr_reg;
    if (rst_in) begin
      addr_next = asl_pkg::BASE_ADDR + {4'h0, addr_strap_high_in, addr_strap_low_in};
    end
  end

  // strap address register
  always_ff @(posedge sys_clk_in) begin
    addr_reg <= addr_next;
  end

  // state registers
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      st_reg <= T_IDLE;
      ph_reg <= P_ADDR;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      tx_reg <= 8'h00;
      ptr_reg <= 8'h00;
      oe_reg <= 1'b0;
      rd_reg <= 1'b0;
      ack_reg <= 1'b0;
      wr_reg <= 1'b0;
      wa_reg <= 8'h00;
      wd_reg <= 8'h00;
      slot_reg <= 4'h0;
      ovr_reg <= 1'b0;
      left_reg <= 1'b0;
      for (int i = 0; i < REG_DEPTH; i++) begin
        mem_reg[i] <= asl_pkg::REG_RST;
      end
    end else begin
      st_reg <= st_next;
      ph_reg <= ph_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      tx_reg <= tx_next;
      ptr_reg <= ptr_next;
      oe_reg <= oe_next;
      rd_reg <= rd_next;
      ack_reg <= ack_next;
      wr_reg <= wr_next;
      wa_reg <= wa_next;
      wd_reg <= wd_next;
      slot_reg <= slot_next;
      ovr_reg <= ovr_next;
      left_reg <= left_next;
      mem_reg <= mem_next;
    end
  end

  assign bus_target_address_out = addr_reg;
  assign slot_out = slot_reg;
  assign slot_source_override_out = ovr_reg;
  assign left_channel_out = left_reg;
  assign reg_wr_out = wr_reg;
  assign reg_wr_addr_out = wa_reg;
  assign reg_wr_data_out = wd_reg;
  assign busy_out = (st_reg != T_IDLE);
endmodule : asl_target

//--- rtl/asl_pkg.sv
// What this block does
// - two straps pick one of eight addresses
// - default slot equals address offset from base
// - override bit selects programmed slot field instead
// - standard I2S: slot 0 right, 1 left
// - justified formats: slot 0 left, 1 right
// - port works at 100 and 400 kHz
// - target only, no stretching, single controller
// - first byte: address high, direction bit low
// - bytes msb first, receiver acknowledges each
// - start/stop are sda edges while scl high
// - sda changes only while scl low
// - target holds sda low through acknowledge
// - unlimited bytes between start and stop
// - write: address, register, data, all acknowledged
// - write data goes to incrementing registers
// - read: set register, repeated start, read address
// - controller nacks last byte, target releases
package asl_pkg;
  // timing
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned SCL_STD_HZ = 100_000;
  localparam int unsigned SCL_FAST_HZ = 400_000;
  // quarter bit periods, rounded up so the bus never runs above the rate
  localparam int unsigned QTR_STD = (CLK_HZ + 4 * SCL_STD_HZ - 1) / (4 * SCL_STD_HZ);
  localparam int unsigned QTR_FAST = (CLK_HZ + 4 * SCL_FAST_HZ - 1) / (4 * SCL_FAST_HZ);
  // addressing
  localparam logic [6:0] BASE_ADDR = 7'h6C;
  localparam logic [7:0] REG_FMT = 8'h02;
  localparam logic [7:0] REG_SLOT = 8'h03;
  localparam int unsigned FMT_LSB = 0;
  localparam int unsigned OVR_BIT = 6;
  localparam int unsigned SLOT_LSB = 0;
  localparam logic [2:0] FMT_I2S = 3'h4;
  localparam logic [7:0] REG_RST = 8'h00;
  // controller byte stages
  typedef enum {S_AW, S_REG, S_WD, S_AR, S_RD} asl_stage_t;
endpackage : asl_pkg

//--- rtl/asl_bus_if.sv
`timescale 1ns/1ps
interface asl_bus_if;
  logic host_scl_o, host_scl_oe, host_sda_o, host_sda_oe;
  logic tgt_sda_o, tgt_sda_oe;
  logic scl, sda;
  // wired-and with pull-ups
  assign scl = host_scl_oe ? host_scl_o : 1'b1;
  assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (tgt_sda_oe ? tgt_sda_o : 1'b1);
  modport host (output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe, input scl, sda);
  modport target (output tgt_sda_o, tgt_sda_oe, input scl, sda);
endinterface : asl_bus_if

//--- rtl/asl_line_mon.sv
`timescale 1ns/1ps
module asl_line_mon (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // bus lines
  input wire logic scl_in,
  input wire logic sda_in,
  // events
  output logic sda_out,
  output logic start_out,
  output logic stop_out,
  output logic rise_out,
  output logic fall_out
);
  logic scl_reg, sda_reg, scl_old_reg, sda_old_reg;
  // one stage of history, lines idle high
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      scl_old_reg <= 1'b1;
      sda_old_reg <= 1'b1;
    end else begin
      scl_reg <= scl_in;
      sda_reg <= sda_in;
      scl_old_reg <= scl_reg;
      sda_old_reg <= sda_reg;
    end
  end
  // sda edges with scl high both samples are bus conditions
  assign start_out = scl_old_reg & scl_reg & sda_old_reg & ~sda_reg;
  assign stop_out = scl_old_reg & scl_reg & ~sda_old_reg & sda_reg;
  assign rise_out = ~scl_old_reg & scl_reg;
  assign fall_out = scl_old_reg & ~scl_reg;
  assign sda_out = sda_reg;
endmodule : asl_line_mon

//--- rtl/asl_ctrl.sv
`timescale 1ns/1ps
module asl_ctrl #(
  parameter bit FAST_MODE = 1'b1
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // bus side
  asl_bus_if.host bus,
  // command
  input wire logic cmd_valid_in,
  input wire logic cmd_read_in,
  input wire logic [6:0] cmd_dev_in,
  input wire logic [7:0] cmd_reg_in,
  input wire logic [7:0] cmd_len_in,
  output logic cmd_ready_out,
  // write data
  input wire logic [7:0] wr_data_in,
  output logic wr_take_out,
  // read data and status
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  output logic done_out,
  output logic nack_out
);
  // rate picks the quarter period
  localparam int unsigned QTR = FAST_MODE ? asl_pkg::QTR_FAST : asl_pkg::QTR_STD;
  localparam logic [7:0] QTR_LOAD = 8'(QTR - 1);
  typedef enum {H_IDLE, H_START, H_BYTE, H_STOP} asl_hstate_t;

  asl_hstate_t st_reg, st_next;
  asl_pkg::asl_stage_t stg_reg, stg_next;
  logic [7:0] tmr_reg, tmr_next;
  logic [1:0] q_reg, q_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] tx_reg, tx_next, rx_reg, rx_next, len_reg, len_next, reg_reg, reg_next;
  logic [6:0] dev_reg, dev_next;
  logic rd_reg, rd_next, ack_reg, ack_next;
  logic scl_oe_reg, scl_oe_next, sda_oe_reg, sda_oe_next;
  logic take_reg, take_next, rv_reg, rv_next, done_reg, done_next, nack_reg, nack_next;
  logic [7:0] rdat_reg, rdat_next;
  logic tick, go_byte, go_stop;

  // pull-down for a bit slot: data msb first, or our ack while reading
  function automatic logic drv(input asl_pkg::asl_stage_t s, input logic [3:0] b,
                               input logic [7:0] t, input logic [7:0] n);
    if (b[3]) begin
      drv = (s == asl_pkg::S_RD) && (n != 8'h01);
    end else begin
      drv = (s != asl_pkg::S_RD) && !t[3'(4'h7 - b)];
    end
  endfunction : drv

  assign tick = (tmr_reg == 8'h00);

  // bit engine: scl high one quarter, low three; sda moves while high only for start and stop
  always_comb begin
    st_next = st_reg;
    stg_next = stg_reg;
    tmr_next = tick ? QTR_LOAD : tmr_reg - 8'h01;
    q_next = q_reg;
    bit_next = bit_reg;
    tx_next = tx_reg;
    rx_next = rx_reg;
    len_next = len_reg;
    reg_next = reg_reg;
    dev_next = dev_reg;
    rd_next = rd_reg;
    ack_next = ack_reg;
    scl_oe_next = scl_oe_reg;
    sda_oe_next = sda_oe_reg;
    take_next = 1'b0;
    rv_next = 1'b0;
    done_next = 1'b0;
    nack_next = nack_reg;
    rdat_next = rdat_reg;
    go_byte = 1'b0;
    go_stop = 1'b0;
    case (st_reg)
      H_IDLE: begin
        if (cmd_valid_in) begin
          dev_next = cmd_dev_in;
          reg_next = cmd_reg_in;
          rd_next = cmd_read_in;
          len_next = (cmd_read_in && cmd_len_in == 8'h00) ? 8'h01 : cmd_len_in;
          tx_next = {cmd_dev_in, 1'b0};
          stg_next = asl_pkg::S_AW;
          nack_next = 1'b0;
          q_next = 2'h0;
          tmr_next = QTR_LOAD;
          st_next = H_START;
        end
      end
      H_START: if (tick) begin
        q_next = q_reg + 2'h1;
        case (q_reg)
          2'h0: sda_oe_next = 1'b0;
          2'h1: scl_oe_next = 1'b0;
          2'h2: sda_oe_next = 1'b1;
          default: begin
            scl_oe_next = 1'b1;
            bit_next = 4'h0;
            st_next = H_BYTE;
          end
        endcase
        if (q_reg == 2'h3) begin
          sda_oe_next = drv(stg_reg, 4'h0, tx_reg, len_reg);
        end
      end
      H_BYTE: if (tick) begin
        q_next = q_reg + 2'h1;
        case (q_reg)
          2'h0: scl_oe_next = 1'b0;
          2'h1: begin
            scl_oe_next = 1'b1;
            if (bit_reg[3]) begin
              ack_next = ~bus.sda;
            end else begin
              rx_next = {rx_reg[6:0], bus.sda};
            end
          end
          2'h2: ;
          default: begin
            bit_next = bit_reg + 4'h1;
            sda_oe_next = drv(stg_reg, bit_reg + 4'h1, tx_reg, len_reg);
            if (bit_reg[3]) begin
              case (stg_reg)
                asl_pkg::S_RD: begin
                  rv_next = 1'b1;
                  rdat_next = rx_reg;
                  len_next = len_reg - 8'h01;
                  go_stop = (len_reg == 8'h01);
                  go_byte = !go_stop;
                end
                default: begin
                  if (!ack_reg) begin
                    nack_next = 1'b1;
                    go_stop = 1'b1;
                  end else if (stg_reg == asl_pkg::S_AW) begin
                    stg_next = asl_pkg::S_REG;
                    tx_next = reg_reg;
                    go_byte = 1'b1;
                  end else if (stg_reg == asl_pkg::S_AR) begin
                    stg_next = asl_pkg::S_RD;
                    go_byte = 1'b1;
                  end else if (stg_reg == asl_pkg::S_REG && rd_reg) begin
                    stg_next = asl_pkg::S_AR;
                    tx_next = {dev_reg, 1'b1};
                    q_next = 2'h0;
                    sda_oe_next = 1'b0;
                    st_next = H_START;
                  end else if (len_reg == 8'h00) begin
                    go_stop = 1'b1;
                  end else begin
                    stg_next = asl_pkg::S_WD;
                    tx_next = wr_data_in;
                    take_next = 1'b1;
                    len_next = len_reg - 8'h01;
                    go_byte = 1'b1;
                  end
                end
              endcase
            end
          end
        endcase
        if (go_byte) begin
          bit_next = 4'h0;
          sda_oe_next = drv(stg_next, 4'h0, tx_next, len_next);
        end
        if (go_stop) begin
          sda_oe_next = 1'b1;
          q_next = 2'h0;
          st_next = H_STOP;
        end
      end
      H_STOP: if (tick) begin
        q_next = q_reg + 2'h1;
        case (q_reg)
          2'h0: scl_oe_next = 1'b0;
          2'h1: sda_oe_next = 1'b0;
          default: begin
            done_next = 1'b1;
            st_next = H_IDLE;
          end
        endcase
      end
      default: st_next = H_IDLE;
    endcase
  end

  // registers
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      st_reg <= H_IDLE;
      stg_reg <= asl_pkg::S_AW;
      tmr_reg <= 8'h00;
      q_reg <= 2'h0;
      bit_reg <= 4'h0;
      tx_reg <= 8'h00;
      rx_reg <= 8'h00;
      len_reg <= 8'h00;
      reg_reg <= 8'h00;
      dev_reg <= 7'h00;
      rd_reg <= 1'b0;
      ack_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      take_reg <= 1'b0;
      rv_reg <= 1'b0;
      done_reg <= 1'b0;
      nack_reg <= 1'b0;
      rdat_reg <= 8'h00;
    end else begin
      st_reg <= st_next;
      stg_reg <= stg_next;
      tmr_reg <= tmr_next;
      q_reg <= q_next;
      bit_reg <= bit_next;
      tx_reg <= tx_next;
      rx_reg <= rx_next;
      len_reg <= len_next;
      reg_reg <= reg_next;
      dev_reg <= dev_next;
      rd_reg <= rd_next;
      ack_reg <= ack_next;
      scl_oe_reg <= scl_oe_next;
      sda_oe_reg <= sda_oe_next;
      take_reg <= take_next;
      rv_reg <= rv_next;
      done_reg <= done_next;
      nack_reg <= nack_next;
      rdat_reg <= rdat_next;
    end
  end

  // sole controller, no arbitration logic
  assign bus.host_scl_o = 1'b0;
  assign bus.host_scl_oe = scl_oe_reg;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_sda_oe = sda_oe_reg;
  assign cmd_ready_out = (st_reg == H_IDLE);
  assign wr_take_out = take_reg;
  assign rd_data_out = rdat_reg;
  assign rd_valid_out = rv_reg;
  assign done_out = done_reg;
  assign nack_out = nack_reg;
endmodule : asl_ctrl

//--- verif/asl_bus_props.sv
`timescale 1ns/1ps
module asl_bus_props (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // host drivers
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  // target drivers
  input wire logic tgt_sda_o,
  input wire logic tgt_sda_oe,
  // resolved lines
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  // a target edge with scl high would look like a start or stop
  a_tgt_low_change: assert property (
    $changed(tgt_sda_oe) |-> !scl) else $error("target moved sda while scl high");
  a_ack_held: assert property (
    $rose(scl) && tgt_sda_oe |-> tgt_sda_oe[*8]) else $error("target let go of sda in high phase");
  a_no_collide: assert property (
    $rose(scl) |-> !(host_sda_oe && tgt_sda_oe)) else $error("both parties drive sda");
  // scl still high 28 cycles after rising, just under one quarter at the fast rate
  a_high_min: assert property (
    $rose(scl) |-> ##28 scl) else $error("scl high phase too short");
  a_low_min: assert property (
    $fell(scl) |-> ##28 !scl) else $error("scl low phase too short");
  a_start_hold: assert property (
    $rose(host_sda_oe) && scl |-> ##28 scl ##[1:12] !scl) else $error("start hold wrong");
  a_stop_idle: assert property (
    $fell(host_sda_oe) && scl && $past(scl) |-> (!host_scl_oe && !host_sda_oe)[*8])
    else $error("bus not idle after stop");
  // reset must release the lines whatever state the bus was in
  a_reset_release: assert property (disable iff (1'b0)
    rst_in |=> !tgt_sda_oe && !host_sda_oe && !host_scl_oe) else $error("line held in reset");
  // open-drain drivers only ever pull low
  a_open_drain: assert property (
    !host_scl_o && !host_sda_o && !tgt_sda_o) else $error("a driver would push a line high");
endmodule : asl_bus_props

//--- verif/i2c_slave_addr_slot_select_tb.sv
`timescale 1ns/1ps
module i2c_slave_addr_slot_select_tb;
  // stimulus
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_valid_std = 1'b0;
  logic cmd_read = 1'b0;
  logic [6:0] cmd_dev = 7'h00;
  logic [7:0] cmd_reg = 8'h00;
  logic [7:0] cmd_len = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic [1:0] strap_lo = 2'h0;
  logic strap_hi = 1'b0;
  // design outputs
  logic cmd_ready, wr_take, rd_valid, done, nack, ovr, left, reg_wr, busy;
  logic done_std, reg_wr_std;
  logic [7:0] reg_wr_data_std;
  logic [7:0] rd_data, reg_wr_addr, reg_wr_data;
  logic [6:0] tgt_addr;
  logic [3:0] slot;
  // bench state
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  int seed = 8;
  int wr_n = 0;
  int rd_n = 0;
  int wire_bits = 8;
  logic [2:0] idx = 3'h0;
  logic [2:0] off = 3'h0;
  logic [6:0] dev = 7'h00;
  logic [7:0] exp_wa = 8'h00;
  logic [7:0] wire_byte = 8'h00;
  logic scl_d = 1'b1;
  logic sda_d = 1'b1;
  logic [7:0] wbuf [16];
  logic [7:0] rbuf [16];
  logic [7:0] mem [16];
  logic [7:0] wire_q [$];

  asl_bus_if bus_if ();
  asl_ctrl #(.FAST_MODE(1'b1)) u_asl_ctrl (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .bus(bus_if),
    .cmd_valid_in(cmd_valid), .cmd_read_in(cmd_read), .cmd_dev_in(cmd_dev), .cmd_reg_in(cmd_reg),
    .cmd_len_in(cmd_len), .cmd_ready_out(cmd_ready), .wr_data_in(wr_data), .wr_take_out(wr_take),
    .rd_data_out(rd_data), .rd_valid_out(rd_valid), .done_out(done), .nack_out(nack));
  asl_target #(.REG_DEPTH(16)) u_asl_target (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .bus(bus_if),
    .addr_strap_low_in(strap_lo), .addr_strap_high_in(strap_hi), .bus_target_address_out(tgt_addr),
    .slot_out(slot), .slot_source_override_out(ovr), .left_channel_out(left), .reg_wr_out(reg_wr),
    .reg_wr_addr_out(reg_wr_addr), .reg_wr_data_out(reg_wr_data), .busy_out(busy));
  asl_bus_props u_asl_bus_props (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .host_scl_o(bus_if.host_scl_o), .host_scl_oe(bus_if.host_scl_oe), .host_sda_o(bus_if.host_sda_o),
    .host_sda_oe(bus_if.host_sda_oe), .tgt_sda_o(bus_if.tgt_sda_o), .tgt_sda_oe(bus_if.tgt_sda_oe),
    .scl(bus_if.scl), .sda(bus_if.sda));
  // second pair at the standard rate, same straps and command fields
  asl_bus_if bus_std ();
  asl_ctrl #(.FAST_MODE(1'b0)) u_asl_ctrl_std (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .bus(bus_std),
    .cmd_valid_in(cmd_valid_std), .cmd_read_in(cmd_read), .cmd_dev_in(cmd_dev), .cmd_reg_in(cmd_reg),
    .cmd_len_in(cmd_len), .cmd_ready_out(), .wr_data_in(wr_data), .wr_take_out(),
    .rd_data_out(), .rd_valid_out(), .done_out(done_std), .nack_out());
  asl_target #(.REG_DEPTH(16)) u_asl_target_std (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .bus(bus_std),
    .addr_strap_low_in(strap_lo), .addr_strap_high_in(strap_hi), .bus_target_address_out(),
    .slot_out(), .slot_source_override_out(), .left_channel_out(), .reg_wr_out(reg_wr_std),
    .reg_wr_addr_out(), .reg_wr_data_out(reg_wr_data_std), .busy_out());

  always #10 sys_clk_in = ~sys_clk_in;

  task cmp(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // channel a slot plays under the format in force
  function automatic logic [7:0] exp_left(input logic [3:0] s, input logic i2s);
    exp_left = {7'h00, i2s ? s[0] : ~s[0]};
  endfunction : exp_left

  task finish_test();
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  // one whole transfer; next write byte follows each take pulse
  task automatic run(input logic rd, input logic [6:0] dv, input logic [7:0] rg, input logic [7:0] len,
                     input logic exp_nack);
    int k;
    k = 0;
    rd_n = 0;
    wire_q.delete();
    @(posedge sys_clk_in);
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    cmd_dev <= dv;
    cmd_reg <= rg;
    cmd_len <= len;
    wr_data <= wbuf[0];
    @(posedge sys_clk_in);
    cmd_valid <= 1'b0;
    while (done !== 1'b1) begin
      @(posedge sys_clk_in);
      if (wr_take === 1'b1) begin
        k++;
        wr_data <= wbuf[k % 16];
      end
      if (rd_valid === 1'b1) begin
        rbuf[rd_n % 16] = rd_data;
        rd_n++;
      end
    end
    cmp({7'h00, nack}, {7'h00, exp_nack});
    cmp({6'h00, cmd_ready, busy}, 8'h02);
    cmp(wire_q[0], {dv, 1'b0});
    if (rd) cmp(wire_q[1], {dv, 1'b1});
  endtask : run

  // stored bytes must land at consecutive registers
  always @(posedge sys_clk_in) begin
    if (reg_wr === 1'b1) begin
      cmp(reg_wr_addr, exp_wa + 8'(wr_n));
      cmp(reg_wr_data, wbuf[wr_n % 16]);
      wr_n++;
    end
  end

  // first byte after each start, read off the wire msb first
  always @(posedge sys_clk_in) begin
    if (scl_d && bus_if.scl && sda_d && !bus_if.sda) wire_bits = 0;
    else if (!scl_d && bus_if.scl && wire_bits < 8) begin
      wire_byte = {wire_byte[6:0], bus_if.sda};
      wire_bits++;
      if (wire_bits == 8) wire_q.push_back(wire_byte);
    end
    scl_d = bus_if.scl;
    sda_d = bus_if.sda;
  end

  // hang guard on the whole simulation, above its expected length
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 80000) begin
      mismatches++;
      finish_test();
    end
  end

  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 8'h00;
    off = 3'($random(seed));
    repeat (20) @(posedge sys_clk_in);
    // every strap code, ending on a random one
    for (int a = 0; a < 8; a++) begin
      idx = 3'(a) + off;
      rst_in <= 1'b1;
      strap_lo <= idx[1:0];
      strap_hi <= idx[2];
      repeat (3) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      repeat (4) @(posedge sys_clk_in);
      cmp({1'b0, tgt_addr}, {1'b0, 7'h6C + 7'(idx)});
      cmp({4'h0, slot}, {5'h00, idx});
      cmp({7'h00, left}, exp_left({1'b0, idx}, 1'b0));
    end
    dev = 7'h6C + 7'(idx);
    // override on, standard format, random slot
    wbuf[0] = 8'h44;
    wbuf[1] = 8'($random(seed)) & 8'h0F;
    exp_wa = 8'h02;
    wr_n = 0;
    run(1'b0, dev, 8'h02, 8'h02, 1'b0);
    mem[2] = wbuf[0];
    mem[3] = wbuf[1];
    repeat (4) @(posedge sys_clk_in);
    cmp(8'(wr_n), 8'h02);
    cmp({7'h00, ovr}, 8'h01);
    cmp({4'h0, slot}, wbuf[1]);
    cmp({7'h00, left}, exp_left(wbuf[1][3:0], 1'b1));
    // random burst up to the top register
    exp_wa = 8'h04 + 8'($random(seed) & 7);
    for (int i = 0; i < 16; i++) wbuf[i] = 8'($random(seed));
    wr_n = 0;
    run(1'b0, dev, exp_wa, 8'h10 - exp_wa, 1'b0);
    for (int i = exp_wa; i < 16; i++) mem[i] = wbuf[i - exp_wa];
    cmp(8'(wr_n), 8'h10 - exp_wa);
    // read registers 2 to 15 back in one transfer
    run(1'b1, dev, 8'h02, 8'h0E, 1'b0);
    cmp(8'(rd_n), 8'h0E);
    for (int i = 0; i < 14; i++) cmp(rbuf[i], mem[i + 2]);
    // foreign address: refused, nothing stored
    wr_n = 0;
    run(1'b0, dev ^ 7'h08, 8'h05, 8'h01, 1'b1);
    cmp(8'(wr_n), 8'h00);
    // one byte at the standard rate on the second pair
    @(posedge sys_clk_in);
    cmd_valid_std <= 1'b1;
    cmd_dev <= dev;
    cmd_reg <= 8'h09;
    cmd_len <= 8'h01;
    wr_data <= wbuf[3];
    @(posedge sys_clk_in);
    cmd_valid_std <= 1'b0;
    while (reg_wr_std !== 1'b1) @(posedge sys_clk_in);
    cmp(reg_wr_data_std, wbuf[3]);
    while (done_std !== 1'b1) @(posedge sys_clk_in);
    finish_test();
  end
endmodule : i2c_slave_addr_slot_select_tb
